// >>> hco_board_model.sv
/* Board side of the clock block: crystal source and power-down controller.
   Assumes the design's oscillator and PLL enables are on the same system clock. */
`timescale 1ns/1ps
module hco_board_model #(
   parameter int LOCK_WAIT_CYC = 300
) (
   // Design side
   input wire logic clk_sys,
   input wire logic oscEnable,
   input wire logic pllEnable,
   output logic crystal_in,
   output logic power_down_n,
   // Bench side
   input wire logic pdReq,
   output logic clocksUsable
);
   int lockCnt = 0;
   // Crystal stands still low while the oscillator is off
   initial begin
      crystal_in = 1'b0;
      // Offset keeps crystal edges away from the clk_sys edges
      #2;
      forever begin
         #35;
         crystal_in = (oscEnable === 1'b1) ? ~crystal_in : 1'b0;
      end
   end
   // Power-down moves off the clock edge, as a free board signal
   assign #3 power_down_n = ~pdReq;
   // Lock wait stands for 3 ms, shortened to keep the run brief
   always @(posedge clk_sys) begin
      if (pdReq || pllEnable !== 1'b1) lockCnt <= 0;
      else if (lockCnt < LOCK_WAIT_CYC) lockCnt <= lockCnt + 1;
   end
   assign clocksUsable = (lockCnt == LOCK_WAIT_CYC);
endmodule : hco_board_model

// >>> hco_clock_ctrl.sv
/*
 * Control logic of the motherboard host clock generator: mode decode, shared pins,
 * current multiplier, spread, and the per-output power-down sequence, with an APB slave.
 * Assumes a 100 MHz clk_sys, inputs synchronous to it except power_down_n, and an
 * external analog stage that turns the level and enable outputs into clock buffers.
 */
// Implementation choices: the APB register port and the register addresses.
// Summary of operation
// R1: The three APIC clock outputs are driven when the APIC enable input is high, else off.
// R2: Both selects low runs host at 133 or 100 MHz by speed select, memory at 66.67 or 50.
// R3: Speed low with selects 0,1 keeps host at 100 MHz and stops every other output low.
// R4: Speed low with both selects high tristates all; all three high gives crystal dividers.
// R5: In power-down all clocks stop low, host true drives twice the reference, complement off.
// R6: The asynchronous power-down input is synchronised and taken at each output's own edges.
// R7: After power-down each output shows falling, rising, falling edges before stopping low.
// R8: When every output has stopped, oscillator and PLL turn off until power-down ends.
// R9: Current select 00, 01, 10, 11 gives host multipliers 5, 6, 4, 7.
// R10: Spread enable low applies -0.5 % down-spread at 31.5 kHz to all but the slow ref.
// R11: Memory and host complement outputs are the inverse of their true outputs.
// R12: With APIC enable low the shared pins are live inputs, high they are latched values.
// R13: A slow reference taken straight from the crystal is given in the normal modes.
// R14: A 66.67 MHz fast reference runs in both normal modes whatever the speed select.
// R15: After power-down ends the outside waits 3 ms for PLL lock before using any clock.
// R16: Shared pins are captured once after supply-on reset, never on power-down release.
// R17: Reserved select codes hold every output low.
`timescale 1ns/1ps
module hco_clock_ctrl
   import hco_pkg::*;
#(
   parameter int HOST_PAIRS = 6,
   parameter int SPREAD_STEP_CYC = HCO_SPREAD_STEP_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Control pins
   input wire logic apic_clock_enable_cfg,
   input wire logic host_speed_select,
   input wire logic power_down_n,
   input wire logic current_mult_sel0,
   input wire logic current_mult_sel1,
   input wire logic crystal_in,
   // Shared pins: 0 frequency select A, 1 frequency select B, 2 spread enable (low)
   input wire logic [2:0] sharedPinIn,
   output logic [2:0] apicClkOut,
   output logic [2:0] apicClkOe_n,
   // Host pairs and current setting
   output logic [HOST_PAIRS-1:0] hostClkTrue,
   output logic [HOST_PAIRS-1:0] hostClkComp,
   output logic hostTrueOe_n,
   output logic hostCompOe_n,
   output logic [2:0] hostCurrentMult,
   // Memory and reference outputs
   output logic memRefTrue,
   output logic memRefComp,
   output logic memRefOe_n,
   output logic fastRefOut,
   output logic slowRefOut,
   output logic refOe_n,
   // Analog enables
   output logic oscEnable,
   output logic pllEnable
);

   if (HOST_PAIRS < 1 || HOST_PAIRS > 6) begin : g_chk_pairs
      $error("HOST_PAIRS must be 1 to 6");
   end
   if (SPREAD_STEP_CYC < 1 || SPREAD_STEP_CYC > 255) begin : g_chk_step
      $error("SPREAD_STEP_CYC must be 1 to 255");
   end

   function automatic logic [2:0] multDecode(input logic s0, input logic s1);
      unique case ({s0, s1})
         2'b00: return 3'h5;
         2'b01: return 3'h6;
         2'b10: return 3'h4;
         2'b11: return 3'h7;
      endcase
   endfunction : multDecode

   function automatic logic isReserved(input hco_mode_type m);
      return (m == HCO_MODE_RSV2) || (m == HCO_MODE_RSV5) || (m == HCO_MODE_RSV6);
   endfunction : isReserved

   hco_state_type st_r;
   hco_state_type st_nxt;

   always_comb begin
      logic [2:0] selUse;
      logic spreadOn;
      logic [7:0] triVal;
      logic [31:0] inc;
      logic [63:0] dec;
      logic [32:0] sum;
      logic xtalRise;
      logic [HCO_NUM_CH-1:0] raw;
      logic [HCO_NUM_CH-1:0] active;
      logic allStop;
      logic pdHeld;
      logic normal;
      st_nxt = st_r;
      raw = '0;
      selUse = '0;
      spreadOn = 1'b0;
      triVal = '0;
      xtalRise = 1'b0;
      allStop = 1'b0;
      pdHeld = 1'b0;
      normal = 1'b0;
      active = '0;
      inc = '0;
      dec = '0;
      sum = '0;
      // APB: one wait-free access phase, answer registered in the setup cycle
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = '0;
      if (psel && !penable) begin
         st_nxt.pready = 1'b1;
         if (paddr == HCO_OFS_CTRL) begin
            st_nxt.prdata = {31'h0, st_r.ctrlSpread};
         end else if (paddr == HCO_OFS_STATUS) begin
            st_nxt.prdata = {12'h0, st_r.pinCaptured, st_r.pllRun, st_r.oscRun,
               !st_r.pdSync2, st_r.lvl, st_r.pinLatch, st_r.mode, 5'h0};
            for (int c = 0; c < HCO_NUM_CH; c++) begin
               st_nxt.prdata[c] = (st_r.chState[c] == HCO_CH_STOP);
            end
         end else begin
            st_nxt.pslverr = 1'b1;
         end
      end
      if (psel && penable && pready && pwrite && paddr == HCO_OFS_CTRL) begin
         st_nxt.ctrlSpread = pwdata[0];
      end
      // Power-down synchroniser
      st_nxt.pdSync1 = power_down_n; // see R6
      st_nxt.pdSync2 = st_r.pdSync1;
      // Shared pins caught once after supply-on reset
      if (!st_r.pinCaptured) begin
         st_nxt.pinLatch = sharedPinIn; // see R16
         st_nxt.pinCaptured = 1'b1;
      end
      selUse = apic_clock_enable_cfg ? st_r.pinLatch : sharedPinIn; // see R12
      st_nxt.mode = hco_mode_type'({host_speed_select, selUse[0], selUse[1]});
      normal = (st_nxt.mode == HCO_MODE_N100) || (st_nxt.mode == HCO_MODE_N133);
      spreadOn = !selUse[2] && st_r.ctrlSpread;
      // Spread triangle
      if (st_r.oscRun) begin
         if (st_r.stepCnt >= 8'(SPREAD_STEP_CYC - 1)) begin
            st_nxt.stepCnt = '0;
            st_nxt.sweep = st_r.sweep + 9'h1;
         end else begin
            st_nxt.stepCnt = st_r.stepCnt + 8'h1;
         end
      end
      triVal = st_r.sweep[8] ? ~st_r.sweep[7:0] : st_r.sweep[7:0];
      // Per-channel phase accumulators
      for (int c = 0; c < HCO_NUM_NCO; c++) begin
         unique case (c)
            HCO_CH_HOST: inc = (st_nxt.mode == HCO_MODE_N133) ?
               hco_inc(HCO_F_HOST133_KHZ) : hco_inc(HCO_F_HOST100_KHZ); // see R2
            HCO_CH_MEM: inc = (st_nxt.mode == HCO_MODE_N133) ?
               hco_inc(HCO_F_MEM66_KHZ) : hco_inc(HCO_F_MEM50_KHZ);
            HCO_CH_FAST: inc = hco_inc(HCO_F_FAST_KHZ); // see R14
            default: inc = hco_inc(HCO_F_APIC_KHZ);
         endcase
         dec = spreadOn ? ((64'(inc) * 64'(triVal) * 64'(HCO_SPREAD_GAIN))
            >> HCO_SPREAD_SHIFT) : 64'h0; // see R10
         sum = {1'b0, st_r.phase[c]} + {1'b0, inc - dec[31:0]};
         if (st_r.oscRun) begin
            st_nxt.phase[c] = sum[31:0];
         end
         raw[c] = st_r.lvl[c] ^ (st_r.oscRun && sum[32]);
      end
      // Test mode dividers from the crystal
      xtalRise = crystal_in && !st_r.xtalPrev;
      st_nxt.xtalPrev = crystal_in;
      if (st_nxt.mode == HCO_MODE_TEST) begin
         if (xtalRise && st_r.oscRun) begin
            st_nxt.xtalDiv = st_r.xtalDiv + 3'h1;
         end
         raw[HCO_CH_HOST] = st_nxt.xtalDiv[0]; // see R4
         raw[HCO_CH_MEM] = st_nxt.xtalDiv[1];
         raw[HCO_CH_FAST] = st_nxt.xtalDiv[1];
         raw[HCO_CH_APIC] = st_nxt.xtalDiv[2];
      end
      raw[HCO_CH_SLOW] = st_r.oscRun && crystal_in; // see R13
      // Which channels carry a clock in this mode
      active[HCO_CH_HOST] = normal || st_nxt.mode == HCO_MODE_PART
         || st_nxt.mode == HCO_MODE_TEST; // see R3
      for (int c = 1; c < HCO_NUM_CH; c++) begin
         active[c] = normal || st_nxt.mode == HCO_MODE_TEST;
      end
      active[HCO_CH_APIC] = active[HCO_CH_APIC] && apic_clock_enable_cfg;
      // Per-output stop sequence, each sampling power-down at its own edges
      for (int c = 0; c < HCO_NUM_CH; c++) begin
         unique case (st_r.chState[c])
            HCO_CH_RUN: begin
               if (!st_r.pdSync2 && !active[c]) begin
                  st_nxt.chState[c] = HCO_CH_STOP;
               end else if (!st_r.pdSync2 && raw[c] != st_r.lvl[c]) begin
                  st_nxt.chState[c] = HCO_CH_WAIT_F1; // see R6
               end
            end
            HCO_CH_WAIT_F1: begin
               if (st_r.lvl[c] && !raw[c]) begin
                  st_nxt.chState[c] = HCO_CH_WAIT_R; // see R7
               end
            end
            HCO_CH_WAIT_R: begin
               if (!st_r.lvl[c] && raw[c]) begin
                  st_nxt.chState[c] = HCO_CH_WAIT_F2; // see R7
               end
            end
            HCO_CH_WAIT_F2: begin
               if (st_r.lvl[c] && !raw[c]) begin
                  st_nxt.chState[c] = HCO_CH_STOP; // see R7
               end
            end
            HCO_CH_STOP: begin
               if (st_r.pdSync2 && st_r.oscRun) begin
                  st_nxt.chState[c] = HCO_CH_RUN;
               end
            end
            default: st_nxt.chState[c] = HCO_CH_STOP;
         endcase
         st_nxt.lvl[c] = (st_nxt.chState[c] != HCO_CH_STOP) && active[c] && raw[c];
      end
      // Oscillator and PLL shut off once every output is parked
      allStop = 1'b1;
      for (int c = 0; c < HCO_NUM_CH; c++) begin
         allStop = allStop && (st_r.chState[c] == HCO_CH_STOP);
      end
      if (st_r.pdSync2) begin
         st_nxt.oscRun = 1'b1;
      end else if (allStop) begin
         st_nxt.oscRun = 1'b0; // see R8
      end
      st_nxt.pllRun = st_nxt.oscRun;
      pdHeld = !st_r.pdSync2 && st_nxt.chState[HCO_CH_HOST] == HCO_CH_STOP;
      // Output stage
      st_nxt.currentMult = pdHeld ? HCO_MULT_PD
         : multDecode(current_mult_sel0, current_mult_sel1); // see R9
      st_nxt.hostTrue = pdHeld || st_nxt.lvl[HCO_CH_HOST]; // see R5
      st_nxt.hostComp = !pdHeld && active[HCO_CH_HOST] && !st_nxt.lvl[HCO_CH_HOST]
         && st_nxt.chState[HCO_CH_HOST] != HCO_CH_STOP; // see R11
      st_nxt.hostTrueOeN = !pdHeld && st_nxt.mode == HCO_MODE_TRI;
      st_nxt.hostCompOeN = pdHeld || st_nxt.mode == HCO_MODE_TRI; // see R5
      st_nxt.memTrue = st_nxt.lvl[HCO_CH_MEM];
      st_nxt.memComp = active[HCO_CH_MEM] && !st_nxt.lvl[HCO_CH_MEM]
         && st_nxt.chState[HCO_CH_MEM] != HCO_CH_STOP; // see R11
      st_nxt.memOeN = st_r.pdSync2 && st_nxt.mode == HCO_MODE_TRI; // see R4
      st_nxt.fastOut = st_nxt.lvl[HCO_CH_FAST];
      st_nxt.slowOut = st_nxt.lvl[HCO_CH_SLOW];
      st_nxt.refOeN = st_r.pdSync2 && st_nxt.mode == HCO_MODE_TRI;
      for (int i = 0; i < 3; i++) begin
         st_nxt.apicOut[i] = st_nxt.lvl[HCO_CH_APIC];
         st_nxt.apicOeN[i] = !apic_clock_enable_cfg
            || (st_r.pdSync2 && st_nxt.mode == HCO_MODE_TRI); // see R1
      end
      if (isReserved(st_nxt.mode)) begin
         st_nxt.memComp = 1'b0; // see R17
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_r <= '{ctrlSpread: HCO_CTRL_RESET, hostTrueOeN: 1'b1, hostCompOeN: 1'b1,
            memOeN: 1'b1, refOeN: 1'b1, apicOeN: 3'h7, mode: HCO_MODE_N100,
            chState: '{default: HCO_CH_RUN}, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign apicClkOut = st_r.apicOut;
   assign apicClkOe_n = st_r.apicOeN;
   assign hostClkTrue = {HOST_PAIRS{st_r.hostTrue}};
   assign hostClkComp = {HOST_PAIRS{st_r.hostComp}};
   assign hostTrueOe_n = st_r.hostTrueOeN;
   assign hostCompOe_n = st_r.hostCompOeN;
   assign hostCurrentMult = st_r.currentMult;
   assign memRefTrue = st_r.memTrue;
   assign memRefComp = st_r.memComp;
   assign memRefOe_n = st_r.memOeN;
   assign fastRefOut = st_r.fastOut;
   assign slowRefOut = st_r.slowOut;
   assign refOe_n = st_r.refOeN;
   assign oscEnable = st_r.oscRun;
   assign pllEnable = st_r.pllRun;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   logic running;
   assign running = st_r.pdSync2 && st_r.oscRun;

   a_apic_off_cfg: assert property (!apic_clock_enable_cfg |=> &apicClkOe_n) // see R1
      else $error("APIC outputs driven while disabled");
   a_mem_invert: assert property ((st_r.mode == HCO_MODE_N100 && running
      && st_r.chState[HCO_CH_MEM] == HCO_CH_RUN) |-> (memRefComp != memRefTrue)) // see R11
      else $error("Memory complement not inverted");
   a_partial_low: assert property ((st_r.mode == HCO_MODE_PART)
      |-> (!fastRefOut && !slowRefOut && !memRefTrue && !memRefComp)) // see R3
      else $error("Partial mode output not low");
   a_test_slow: assert property ((st_r.mode == HCO_MODE_TEST && running
      && st_r.chState[HCO_CH_SLOW] == HCO_CH_RUN) |-> slowRefOut == $past(crystal_in)) // see R4
      else $error("Slow ref does not follow crystal");
   a_pd_host: assert property ((!st_r.pdSync2 && st_r.chState[HCO_CH_HOST] == HCO_CH_STOP)
      |-> (hostClkTrue[0] && hostCompOe_n && hostCurrentMult == HCO_MULT_PD
      && (st_r.chState[HCO_CH_MEM] != HCO_CH_STOP || !memRefTrue))) // see R5
      else $error("Power-down output state wrong");
   a_pd_sync: assert property ($fell(power_down_n) ##1 !power_down_n |=> !st_r.pdSync2) // see R6
      else $error("Power-down not synchronised in two cycles");
   a_stop_last_fall: assert property ((st_r.chState[HCO_CH_HOST] == HCO_CH_STOP
      && $past(st_r.chState[HCO_CH_HOST]) == HCO_CH_WAIT_F2) |-> $past(st_r.lvl[0])) // see R7
      else $error("Host stopped without final falling edge");
   a_osc_off: assert property ($fell(oscEnable)
      |-> (!st_r.pdSync2 && $past(st_r.chState[HCO_CH_FAST]) == HCO_CH_STOP)) // see R8
      else $error("Oscillator stopped before outputs");
   a_mult_map: assert property ((running && $past(running)
      && st_r.chState[HCO_CH_HOST] == HCO_CH_RUN) |-> hostCurrentMult ==
      multDecode($past(current_mult_sel0), $past(current_mult_sel1))) // see R9
      else $error("Current multiplier mismatch");
   a_latch_hold: assert property (st_r.pinCaptured |=> $stable(st_r.pinLatch)) // see R16
      else $error("Shared pin latch changed");
   a_rsv_low: assert property (isReserved(st_r.mode)
      |-> (!hostClkTrue[0] || !st_r.pdSync2) && !memRefTrue && !apicClkOut[0]) // see R17
      else $error("Reserved mode output not low");

   c_pd_done: cover property (!st_r.pdSync2 ##1 $fell(oscEnable));
   c_test_mode: cover property (st_r.mode == HCO_MODE_TEST && $rose(memRefTrue));
   c_n133: cover property (st_r.mode == HCO_MODE_N133 && $rose(hostClkTrue[0]));
   c_apb_err: cover property (pready && pslverr);

endmodule : hco_clock_ctrl

// >>> hco_pkg.sv
/*
 * Constants, modes and the state record of the host clock output control block.
 * Assumes one 100 MHz system clock and inputs synchronous to it except power_down_n.
 */
package hco_pkg;

   localparam int HCO_CLK_KHZ = 100000;
   localparam int HCO_RATE_SCALE = 16;
   localparam int HCO_NUM_NCO = 4;
   localparam int HCO_NUM_CH = 5;
   localparam int HCO_CH_HOST = 0;
   localparam int HCO_CH_MEM = 1;
   localparam int HCO_CH_FAST = 2;
   localparam int HCO_CH_APIC = 3;
   localparam int HCO_CH_SLOW = 4;

   // Output rates in kHz, shown at 1/HCO_RATE_SCALE of the real rate
   localparam longint HCO_F_HOST133_KHZ = 133333;
   localparam longint HCO_F_HOST100_KHZ = 100000;
   localparam longint HCO_F_MEM66_KHZ = 66667;
   localparam longint HCO_F_MEM50_KHZ = 50000;
   localparam longint HCO_F_FAST_KHZ = 66667;
   localparam longint HCO_F_APIC_KHZ = 33333;

   function automatic logic [31:0] hco_inc(input longint fKhz);
      longint prod;
      prod = (64'd2 * fKhz * (64'd1 << 32)) / (64'(HCO_RATE_SCALE) * 64'(HCO_CLK_KHZ));
      return prod[31:0];
   endfunction : hco_inc

   // Down-spread: -0.5 % at 31.5 kHz, triangle of 512 steps
   localparam int HCO_SPREAD_HZ = 31500;
   localparam int HCO_SPREAD_STEPS = 512;
   localparam int HCO_SPREAD_STEP_CYC =
      (HCO_CLK_KHZ * 1000) / (HCO_SPREAD_HZ * HCO_SPREAD_STEPS);
   localparam logic [5:0] HCO_SPREAD_GAIN = 6'h29;
   localparam int HCO_SPREAD_SHIFT = 21;

   // Register map
   localparam logic [11:0] HCO_OFS_CTRL = 12'h000;
   localparam logic [11:0] HCO_OFS_STATUS = 12'h004;
   localparam logic HCO_CTRL_RESET = 1'b1;
   localparam logic [2:0] HCO_MULT_PD = 3'h2;

   typedef enum logic [2:0] {
      HCO_MODE_N100 = 3'b000,
      HCO_MODE_PART = 3'b001,
      HCO_MODE_RSV2 = 3'b010,
      HCO_MODE_TRI = 3'b011,
      HCO_MODE_N133 = 3'b100,
      HCO_MODE_RSV5 = 3'b101,
      HCO_MODE_RSV6 = 3'b110,
      HCO_MODE_TEST = 3'b111
   } hco_mode_type;

   typedef enum logic [2:0] {
      HCO_CH_RUN = 3'b000,
      HCO_CH_WAIT_F1 = 3'b001,
      HCO_CH_WAIT_R = 3'b010,
      HCO_CH_WAIT_F2 = 3'b011,
      HCO_CH_STOP = 3'b100
   } hco_ch_state_type;

   typedef struct packed {
      logic ctrlSpread;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic pdSync1;
      logic pdSync2;
      logic pinCaptured;
      logic [2:0] pinLatch;
      hco_mode_type mode;
      logic [HCO_NUM_NCO-1:0][31:0] phase;
      logic [8:0] sweep;
      logic [7:0] stepCnt;
      logic xtalPrev;
      logic [2:0] xtalDiv;
      logic [HCO_NUM_CH-1:0] lvl;
      hco_ch_state_type [HCO_NUM_CH-1:0] chState;
      logic oscRun;
      logic pllRun;
      logic hostTrue;
      logic hostComp;
      logic hostTrueOeN;
      logic hostCompOeN;
      logic [2:0] currentMult;
      logic memTrue;
      logic memComp;
      logic memOeN;
      logic fastOut;
      logic slowOut;
      logic refOeN;
      logic [2:0] apicOut;
      logic [2:0] apicOeN;
   } hco_state_type;

endpackage : hco_pkg

// >>> test_mp_host_clock_output_control.sv
/* Self-checking bench of the host clock output control block.
   Assumes the package, the design and the board model are compiled first. */
`timescale 1ns/1ps
module test_mp_host_clock_output_control;
   import hco_pkg::*;
   logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, err, compBad, prevMem;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, r;
   logic apicCfg, speedSel, cms0, cms1, xtal, pdN, pdReq, usable;
   logic [2:0] sPin, apicOut, apicOe_n, mult, m;
   logic [5:0] hostT, hostC;
   logic hTOe_n, hCOe_n, memT, memC, memOe_n, fastRef, slowRef, refOe_n, oscEn, pllEn;
   logic [4:0] lv, ex;
   int fails = 0;
   int checksDone = 0;
   int memRise;
   int tog[5], t100[5], t133[5], tTst[5];
   int multExp[4] = '{5, 6, 4, 7};
   hco_clock_ctrl #(.SPREAD_STEP_CYC(1)) hco_clock_ctrl_i (
      .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .apic_clock_enable_cfg(apicCfg), .host_speed_select(speedSel), .power_down_n(pdN),
      .current_mult_sel0(cms0), .current_mult_sel1(cms1), .crystal_in(xtal),
      .sharedPinIn(sPin), .apicClkOut(apicOut), .apicClkOe_n(apicOe_n),
      .hostClkTrue(hostT), .hostClkComp(hostC), .hostTrueOe_n(hTOe_n),
      .hostCompOe_n(hCOe_n), .hostCurrentMult(mult), .memRefTrue(memT),
      .memRefComp(memC), .memRefOe_n(memOe_n), .fastRefOut(fastRef),
      .slowRefOut(slowRef), .refOe_n(refOe_n), .oscEnable(oscEn), .pllEnable(pllEn));
   hco_board_model #(.LOCK_WAIT_CYC(300)) hco_board_model_i (
      .clk_sys(clk_sys), .oscEnable(oscEn), .pllEnable(pllEn), .crystal_in(xtal),
      .power_down_n(pdN), .pdReq(pdReq), .clocksUsable(usable));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic endOfTest();
      $display("checks %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : endOfTest
   task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chkReg
   task automatic chkPin(input logic [7:0] got, input logic [7:0] exp);
      chkReg({24'h0, got}, {24'h0, exp});
   endtask : chkPin
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Mode code is {speed, select A, select B}
   task automatic setMode(input logic [2:0] md);
      @(posedge clk_sys);
      speedSel <= md[2];
      sPin <= {1'b1, md[0], md[1]};
      repeat (40) @(posedge clk_sys);
   endtask : setMode
   // Counts toggles of host, mem, fast, apic and slow over 128 cycles
   task automatic watch(input logic [4:0] act);
      logic [4:0] prev;
      tog = '{default: 0};
      compBad = 1'b0;
      prev = 5'h0;
      for (int i = 0; i < 129; i++) begin
         @(posedge clk_sys);
         #1;
         lv = {slowRef, apicOut[0], fastRef, memT, hostT[0]};
         if (i > 0) for (int c = 0; c < 5; c++) tog[c] += int'(lv[c] != prev[c]);
         prev = lv;
         if (!memOe_n && memC !== (act[1] & ~memT)) compBad = 1'b1;
         if (!hCOe_n && hostC !== ({6{act[0]}} & ~hostT)) compBad = 1'b1;
      end
   endtask : watch
   function automatic logic [4:0] expAct(input logic [2:0] md, input logic cfg);
      case (md)
         3'b000, 3'b100, 3'b111: return {1'b1, cfg, 3'b111};
         3'b001: return 5'b00001;
         default: return 5'b00000;
      endcase
   endfunction : expAct
   function automatic logic near(input int a, input int b);
      return (a >= b - 1) && (a <= b + 1);
   endfunction : near
   initial begin
      repeat (30000) @(posedge clk_sys);
      fails++;
      $display("unexpected at %0t: watchdog expired", $time);
      endOfTest();
   end
   initial begin
      void'($urandom(32'h670a));
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      apicCfg = 1'b0;
      speedSel = 1'b0;
      sPin = 3'b100;
      cms0 = 1'b0;
      cms1 = 1'b0;
      pdReq = 1'b0;
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      apb(1'b0, HCO_OFS_CTRL, 32'h0);
      chkReg(rd, {31'h0, HCO_CTRL_RESET});
      apb(1'b1, HCO_OFS_CTRL, 32'h0);
      apb(1'b0, HCO_OFS_CTRL, 32'h0);
      chkReg(rd, 32'h0);
      apb(1'b1, HCO_OFS_CTRL, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chkReg({err, rd[30:0]}, 32'h80000000);
      $display("test registers done");
      for (int s = 0; s < 4; s++) begin
         @(posedge clk_sys);
         cms0 <= s[1];
         cms1 <= s[0];
         repeat (3) @(posedge clk_sys);
         chkPin({5'h0, mult}, 8'(multExp[s]));
      end
      $display("test current done");
      r = $urandom;
      for (int i = 0; i < 8; i++) begin
         m = 3'(i) ^ r[2:0];
         setMode(m);
         ex = expAct(m, 1'b0);
         watch(ex);
         apb(1'b0, HCO_OFS_STATUS, 32'h0);
         chkPin({5'h0, rd[7:5]}, {5'h0, m});
         chkPin({3'h0, tog[4] > 0, tog[3] > 0, tog[2] > 0, tog[1] > 0, tog[0] > 0}, {3'h0, ex});
         chkPin({7'h0, compBad}, 8'h0);
         if (m != 3'b011) chkPin({3'h0, lv & ~ex}, 8'h0);
         if (m == 3'b011) chkPin({1'b0, hTOe_n, hCOe_n, memOe_n, refOe_n, apicOe_n}, 8'h7f);
         if (m == 3'b000) t100 = tog;
         if (m == 3'b100) t133 = tog;
         if (m == 3'b111) tTst = tog;
      end
      chkPin(8'(near(t133[0], t100[0] * 4 / 3)), 8'h1);
      chkPin(8'(near(t133[1], t100[1] * 4 / 3)), 8'h1);
      chkPin(8'(near(t133[2], t100[2])), 8'h1);
      chkPin(8'(near(t100[4], tTst[4])), 8'h1);
      chkPin(8'(near(tTst[0], tTst[4] / 2)), 8'h1);
      chkPin(8'(near(tTst[1], tTst[4] / 4)), 8'h1);
      $display("test modes done");
      setMode(3'b100);
      apicCfg <= 1'b1;
      sPin <= 3'($urandom) | 3'b001;
      repeat (40) @(posedge clk_sys);
      watch(expAct(3'b100, 1'b1));
      chkPin({5'h0, apicOe_n}, 8'h0);
      chkPin({7'h0, compBad}, 8'h0);
      chkPin({7'h0, tog[3] > 0}, 8'h1);
      apb(1'b0, HCO_OFS_STATUS, 32'h0);
      chkPin({5'h0, rd[7:5]}, 8'h04);
      $display("test apic done");
      pdReq <= 1'b1;
      memRise = 0;
      prevMem = memT;
      for (int k = 0; k < 400 && oscEn !== 1'b0; k++) begin
         @(posedge clk_sys);
         #1;
         if (memT && !prevMem) memRise++;
         prevMem = memT;
      end
      chkPin(8'(memRise > 0), 8'h1);
      chkPin({oscEn, pllEn, memT, fastRef, slowRef, apicOut}, 8'h0);
      chkPin({hostT, hCOe_n, 1'b0}, 8'hfe);
      chkPin({5'h0, mult}, {5'h0, HCO_MULT_PD});
      apb(1'b0, HCO_OFS_STATUS, 32'h0);
      chkPin({3'h0, rd[4:0]}, 8'h1f);
      @(posedge clk_sys);
      pdReq <= 1'b0;
      for (int k = 0; k < 2000 && usable !== 1'b1; k++) @(posedge clk_sys);
      chkPin({6'h0, oscEn, pllEn}, 8'h03);
      apb(1'b0, HCO_OFS_STATUS, 32'h0);
      chkPin({5'h0, rd[10:8]}, 8'h04);
      watch(expAct(3'b100, 1'b1));
      chkPin({7'h0, tog[0] > 0}, 8'h1);
      apicCfg <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chkPin({5'h0, apicOe_n}, 8'h07);
      $display("test power-down done");
      endOfTest();
   end
endmodule : test_mp_host_clock_output_control
